// file: core/ctrl_decode_consts.svh
// How it works
// RL1: Configuration-load copies the accumulator into the prescaler config register; flags untouched.
// RL2: The prescaler config register is also read and written as an ordinary file register.
// RL3: Configuration-load stays supported for old code; direct register writes are preferred.
// RL4: Interrupt-return pops the return stack and loads stack top into the program counter.
// RL5: Interrupt-return sets the global interrupt enable, bit 7 of the irq control register.
// RL6: Interrupt-return is one word, two cycles; the second cycle flushes the fetched word.
// RL7: Subroutine-return pops the stack into the program counter; enables and flags untouched.
// RL8: Subroutine-return is one word taking two instruction cycles.
// RL9: Idle ignores its two don't-care bits, changes nothing, takes one cycle.
// RL10: Store-accumulator writes the accumulator to the 7-bit addressed file register in one cycle.
`ifndef CTRL_DECODE_CONSTS_SVH
`define CTRL_DECODE_CONSTS_SVH
`define INSTR_W 14
`define FADDR_W 7
`define DATA_W 8
`define PC_W 13
`define OP_IDLE 14'h0000
`define OP_IDLE_MASK 14'h3F9F
`define OP_STORE_ACC 14'h0080
`define OP_STORE_ACC_MASK 14'h3F80
`define OP_CFG_LOAD 14'h0062
`define OP_IRQ_RETURN 14'h0009
`define OP_SUB_RETURN 14'h0008
`define IRQ_EN_BIT 7
`define CFG_REG_ADDR 7'h01
`define CFG_RESET 8'hFF
`endif

// file: core/ctrl_decode_pkg.sv
`include "ctrl_decode_consts.svh"
package ctrl_decode_pkg;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_FLUSH = 2'b01
    } exec_state_e;
    typedef struct packed {
        logic valid;
        logic [`FADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } file_write_s;
    typedef struct packed {
        logic pop;
        logic [`PC_W-1:0] target;
    } pc_load_s;
endpackage

// file: core/ctrl_instr_match.sv
`include "ctrl_decode_consts.svh"
module ctrl_instr_match (
    input wire logic [`INSTR_W-1:0] i_instr, // Fetched instruction word.
    output logic o_idle, // Idle instruction.
    output logic o_store_acc, // Store-accumulator instruction.
    output logic o_cfg_load, // Configuration-load instruction.
    output logic o_irq_ret, // Interrupt-return instruction.
    output logic o_sub_ret // Subroutine-return instruction.
);
    assign o_idle = (i_instr & `OP_IDLE_MASK) == `OP_IDLE; // [RL9]
    assign o_store_acc = (i_instr & `OP_STORE_ACC_MASK) == `OP_STORE_ACC; // [RL10]
    assign o_cfg_load = i_instr == `OP_CFG_LOAD; // [RL1] [RL3]
    assign o_irq_ret = i_instr == `OP_IRQ_RETURN; // [RL4]
    assign o_sub_ret = i_instr == `OP_SUB_RETURN; // [RL7]
endmodule

// file: core/cpu_control_instr_decode.sv
`include "ctrl_decode_consts.svh"
module cpu_control_instr_decode
    import ctrl_decode_pkg::*;
(
    input wire logic i_clk_sys, // Instruction clock.
    input wire logic i_rst_n, // Synchronous reset, active low.
    input wire logic i_instr_valid, // Instruction word is present.
    input wire logic [`INSTR_W-1:0] i_instr, // Instruction word.
    input wire logic [`DATA_W-1:0] i_acc, // Working accumulator.
    input wire logic [`PC_W-1:0] i_stack_top, // Return stack top.
    input wire logic [`DATA_W-1:0] i_irq_ctrl, // Current irq control register.
    input wire logic i_bus_wr, // Datapath file write strobe.
    input wire logic [`FADDR_W-1:0] i_bus_addr, // Datapath file address.
    input wire logic [`DATA_W-1:0] i_bus_wdata, // Datapath file write data.
    output file_write_s o_file_wr, // File register write from store-accumulator.
    output pc_load_s o_pc_load, // Stack pop and program counter load.
    output logic o_irq_ctrl_wr, // Irq control register write strobe.
    output logic [`DATA_W-1:0] o_irq_ctrl_data, // Irq control write data.
    output logic [`DATA_W-1:0] o_cfg_reg, // Prescaler configuration register.
    output logic o_flush, // Discard the fetched instruction.
    output logic o_busy // Second cycle of a two-cycle return.
);
    exec_state_e state_reg, state_next;
    logic is_idle, is_store, is_cfg, is_iret, is_ret;
    file_write_s file_wr_reg, file_wr_next;
    pc_load_s pc_load_reg, pc_load_next;
    logic irq_wr_reg, irq_wr_next;
    logic [`DATA_W-1:0] irq_data_reg, irq_data_next;
    logic [`DATA_W-1:0] cfg_reg, cfg_next;
    logic flush_reg, busy_reg;

    ctrl_instr_match u_match (
        .i_instr(i_instr),
        .o_idle(is_idle),
        .o_store_acc(is_store),
        .o_cfg_load(is_cfg),
        .o_irq_ret(is_iret),
        .o_sub_ret(is_ret)
    );

    // Instructions are ignored during the flush cycle, since that word was fetched past the return.
    wire exec = i_instr_valid && (state_reg == ST_EXEC);
    wire take_ret = exec && (is_iret || is_ret); // [RL6] [RL8]
    wire cfg_by_bus = i_bus_wr && (i_bus_addr == `CFG_REG_ADDR); // [RL2]
    wire cfg_by_instr = exec && is_cfg; // [RL1] [RL3]
    wire cfg_by_store = exec && is_store && (i_instr[`FADDR_W-1:0] == `CFG_REG_ADDR); // [RL2]

    always_comb begin
        state_next = ST_EXEC;
        case (state_reg)
            ST_EXEC: state_next = take_ret ? ST_FLUSH : ST_EXEC; // [RL6] [RL8]
            ST_FLUSH: state_next = ST_EXEC;
            default: state_next = ST_EXEC;
        endcase
    end

    always_comb begin
        file_wr_next.valid = exec && is_store; // [RL10]
        file_wr_next.addr = i_instr[`FADDR_W-1:0];
        file_wr_next.data = i_acc;
        pc_load_next.pop = take_ret; // [RL4] [RL7]
        pc_load_next.target = i_stack_top;
        irq_wr_next = exec && is_iret; // [RL5]
        irq_data_next = i_irq_ctrl;
        irq_data_next[`IRQ_EN_BIT] = 1'b1; // [RL5]
        cfg_next = cfg_reg;
        // Instruction loads win over a datapath write in the same cycle.
        if (cfg_by_bus) begin
            cfg_next = i_bus_wdata; // [RL2]
        end
        if (cfg_by_instr || cfg_by_store) begin
            cfg_next = i_acc; // [RL1]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_reg <= ST_EXEC;
            file_wr_reg <= '0;
            pc_load_reg <= '0;
            irq_wr_reg <= 1'b0;
            irq_data_reg <= '0;
            cfg_reg <= `CFG_RESET;
            flush_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            file_wr_reg <= file_wr_next;
            pc_load_reg <= pc_load_next;
            irq_wr_reg <= irq_wr_next;
            irq_data_reg <= irq_data_next;
            cfg_reg <= cfg_next;
            flush_reg <= take_ret; // [RL6]
            busy_reg <= take_ret;
        end
    end

    assign o_file_wr = file_wr_reg;
    assign o_pc_load = pc_load_reg;
    assign o_irq_ctrl_wr = irq_wr_reg;
    assign o_irq_ctrl_data = irq_data_reg;
    assign o_cfg_reg = cfg_reg;
    assign o_flush = flush_reg;
    assign o_busy = busy_reg;
endmodule

// file: test/irq_ctrl_model.sv
module irq_ctrl_model (
    input wire logic i_clk_sys, i_rst_n, i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // The enable drops after a write, as interrupt entry would, so each interrupt-return must set it again.
    always_ff @(posedge i_clk_sys) o_q <= !i_rst_n ? 8'h3c : i_wr ? i_wdata : o_q & 8'h7f;
endmodule

// file: test/ctrl_decode_monitor.sv
`include "ctrl_decode_consts.svh"
module ctrl_decode_monitor import ctrl_decode_pkg::*; (
    input wire logic i_clk_sys, i_rst_n, i_instr_valid, i_bus_wr, o_irq_ctrl_wr, o_flush, o_busy,
    input wire logic [`INSTR_W-1:0] i_instr,
    input wire logic [`DATA_W-1:0] i_acc, i_irq_ctrl, i_bus_wdata, o_irq_ctrl_data, o_cfg_reg,
    input wire logic [`PC_W-1:0] i_stack_top,
    input wire logic [`FADDR_W-1:0] i_bus_addr,
    input wire file_write_s o_file_wr,
    input wire pc_load_s o_pc_load
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic t;
    assign t = i_instr_valid && !o_flush;
    sequence iret_s; t && i_instr == `OP_IRQ_RETURN; endsequence
    sequence ret_s; iret_s or (t && i_instr == `OP_SUB_RETURN); endsequence
    ret_pop_a: assert property (ret_s |=> o_pc_load == {1'b1, $past(i_stack_top)}) else $error("pop");
    irq_set_a: assert property (iret_s |=> o_irq_ctrl_wr && o_irq_ctrl_data == ($past(i_irq_ctrl) | 8'h80)) else $error("irq");
    sub_keep_a: assert property (t && i_instr == `OP_SUB_RETURN |=> !o_irq_ctrl_wr) else $error("sub");
    ret_flush_a: assert property (ret_s |=> o_flush && o_busy ##1 !o_pc_load.pop) else $error("flush");
    cfg_load_a: assert property (t && i_instr == `OP_CFG_LOAD |=> o_cfg_reg == $past(i_acc)) else $error("cfg");
    store_acc_a: assert property (t && (i_instr & `OP_STORE_ACC_MASK) == `OP_STORE_ACC
        |=> o_file_wr == {1'b1, $past(i_instr[6:0]), $past(i_acc)}) else $error("store");
    idle_quiet_a: assert property (t && !i_bus_wr && (i_instr & `OP_IDLE_MASK) == 0
        |=> !o_pc_load.pop && !o_file_wr.valid && !o_flush && $stable(o_cfg_reg)) else $error("idle");
    bus_cfg_a: assert property (!i_instr_valid && i_bus_wr && i_bus_addr == `CFG_REG_ADDR
        |=> o_cfg_reg == $past(i_bus_wdata)) else $error("bus");
endmodule
bind cpu_control_instr_decode ctrl_decode_monitor mon (.*);

// file: test/test_cpu_control_instr_decode.sv
module test_cpu_control_instr_decode import ctrl_decode_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 0, i_rst_n = 0, i_instr_valid = 0, i_bus_wr = 0, o_irq_ctrl_wr, o_flush, o_busy;
    logic [13:0] i_instr = 0;
    logic [7:0] i_acc = 0, i_bus_wdata = 0, o_irq_ctrl_data, o_cfg_reg, i_irq_ctrl;
    logic [12:0] i_stack_top = 0;
    logic [6:0] i_bus_addr = 0;
    file_write_s o_file_wr;
    pc_load_s o_pc_load;
    int failures = 0, checked = 0, p, ins, tk, e_pop, e_tgt, e_fv, e_fa, e_fd, e_cfg = 255, e_iw, e_id, e_fl;
    int ops[5] = '{0, 'h80, 'h62, 9, 8};
    cpu_control_instr_decode DUT (.*);
    irq_ctrl_model partner (.i_clk_sys, .i_rst_n, .i_wr(o_irq_ctrl_wr), .i_wdata(o_irq_ctrl_data), .o_q(i_irq_ctrl));
    initial forever #5 i_clk_sys = ~i_clk_sys;
    task automatic close_out;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string n, int e, logic [15:0] s);
        checked++;
        if (s !== e[15:0]) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // Reference model: a word in the cycle after a return is not taken.
    always @(posedge i_clk_sys) begin
        ins = i_instr;
        tk = i_rst_n && i_instr_valid && !e_fl;
        e_pop = tk && (ins == 8 || ins == 9);
        e_tgt = i_stack_top;
        e_iw = tk && ins == 9;
        e_id = i_irq_ctrl | 128;
        e_fv = tk && (ins & 'h3f80) == 'h80;
        e_fa = ins & 127;
        e_fd = i_acc;
        e_fl = e_pop;
        if (!i_rst_n) e_cfg = 255;
        else if (tk && ins == 'h62 || e_fv && e_fa == 1) e_cfg = i_acc;
        else if (i_bus_wr && i_bus_addr == 1) e_cfg = i_bus_wdata;
    end
    always @(negedge i_clk_sys) begin
        chk("pop", e_pop, o_pc_load.pop);
        if (e_pop) chk("target", e_tgt, o_pc_load.target);
        chk("irq_wr", e_iw, o_irq_ctrl_wr);
        if (e_iw) chk("irq_data", e_id, o_irq_ctrl_data);
        chk("flush_busy", e_fl * 3, {o_flush, o_busy});
        chk("file_wr", e_fv, o_file_wr.valid);
        if (e_fv) chk("file_data", e_fa * 256 + e_fd, {o_file_wr.addr, o_file_wr.data});
        chk("cfg", e_cfg, o_cfg_reg);
    end
    initial begin
        #10000;
        failures++;
        close_out;
    end
    initial begin
        void'($urandom(32'he012));
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1;
        // Bus writes also land beside taken words, so the instruction's priority over them is exercised.
        for (int n = 0; n < 600; n++) begin
            @(posedge i_clk_sys);
            p = $urandom % 7;
            // A mid-run reset must bring the loaded config register back; no request is made across it.
            i_rst_n <= !(n inside {300, 301});
            i_instr_valid <= p != 5 && !(n inside {300, 301});
            // Unknown words must be ignored, and a third of the stores aim at the config register.
            i_instr <= p == 6 ? 14'($urandom)
                : 14'(ops[p % 5] | (p == 0 ? $urandom & 'h60 : p == 1 ? ($urandom % 3 ? $urandom & 127 : 1) : 0));
            i_bus_wr <= (p == 5 || $urandom % 4 == 0) && !(n inside {300, 301});
            i_bus_addr <= 7'($urandom % 2);
            i_bus_wdata <= 8'($urandom);
            i_acc <= 8'($urandom);
            i_stack_top <= 13'($urandom);
        end
        repeat (3) @(posedge i_clk_sys);
        close_out;
    end
endmodule
